// *** design/asc_serial_ctrl.sv ***
// Serial transmitter and receiver with its two control registers
`include "asc_map.svh"
`default_nettype none
module asc_serial_ctrl #(
    parameter logic [15:0] BAUD_DIV = `ASC_BAUD_DIV_DEF
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Processor wait mode
    input  wire logic       waitMode,
    // Serial pins
    input  wire logic       serialInPin,
    input  wire logic       serialOutI,
    output logic            serialOutO,
    output logic            serialOutOeN,
    // Interrupt request levels
    output logic            txEmptyReq,
    output logic            txDoneReq,
    output logic            rxFullReq,
    output logic            lineQuietReq
);
    import asc_pkg::*;

    asc_state_t state_reg;
    asc_state_t state_next;

    logic       unitRun;
    logic       tick;
    logic       rxIn;
    logic       nineBit;
    logic [3:0] frameLen;
    logic [8:0] txWord;
    logic [8:0] rxWord;
    logic       parBad;
    logic       standby;
    logic       rdLo;
    logic       wrLo;

    // Decoded controls
    assign nineBit  = state_reg.frameLoop[`ASC_FL_CHAR_LEN];
    assign frameLen = nineBit ? `ASC_FRAME_9 : `ASC_FRAME_8;
    assign standby  = state_reg.irqEnable[`ASC_IE_STANDBY];
    assign unitRun  = !(waitMode && state_reg.frameLoop[`ASC_FL_WAIT_HALT]);
    assign tick     = unitRun && (state_reg.baudCnt == BAUD_DIV - 16'h0001);
    assign rdLo     = regRd && (regAddr == `ASC_OFS_DATA_LO);
    assign wrLo     = regWr && (regAddr == `ASC_OFS_DATA_LO);

    // Receiver input routing
    always_comb begin
        if (!state_reg.frameLoop[`ASC_FL_LOOP]) begin
            rxIn = serialInPin;
        end else if (state_reg.frameLoop[`ASC_FL_RX_SOURCE]) begin
            rxIn = serialOutI;
        end else begin
            rxIn = state_reg.txLine;
        end
    end

    // Transmit word with parity in the top data bit
    always_comb begin
        txWord = state_reg.txData;
        if (!nineBit) begin
            txWord[8] = 1'b0;
        end
        if (state_reg.frameLoop[`ASC_FL_PAR_EN]) begin
            if (nineBit) begin
                txWord[8] = ^txWord[7:0] ^ state_reg.frameLoop[`ASC_FL_PAR_ODD];
            end else begin
                txWord[7] = ^txWord[6:0] ^ state_reg.frameLoop[`ASC_FL_PAR_ODD];
            end
        end
    end

    // Received word and parity check
    always_comb begin
        if (nineBit) begin
            rxWord = state_reg.rxShift[9:1];
            parBad = (^rxWord[7:0] ^ state_reg.frameLoop[`ASC_FL_PAR_ODD]) != rxWord[8];
        end else begin
            rxWord = {1'b0, state_reg.rxShift[9:2]};
            parBad = (^rxWord[6:0] ^ state_reg.frameLoop[`ASC_FL_PAR_ODD]) != rxWord[7];
        end
        parBad = parBad && state_reg.frameLoop[`ASC_FL_PAR_EN];
    end

    // Next state
    always_comb begin
        state_next = state_reg;

        // Baud tick divider, held at zero while halted
        if (!unitRun || tick) begin
            state_next.baudCnt = 16'h0000;
        end else begin
            state_next.baudCnt = state_reg.baudCnt + 16'h0001;
        end

        // Read data, one cycle after the strobe
        state_next.rdata = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                `ASC_OFS_FRAME_LOOP: state_next.rdata = state_reg.frameLoop;
                `ASC_OFS_IRQ_ENABLE: state_next.rdata = state_reg.irqEnable;
                `ASC_OFS_STATUS: state_next.rdata = {state_reg.txEmpty, state_reg.txDone,
                    state_reg.rxFull, state_reg.idleFlag, state_reg.overrun, 1'b0,
                    state_reg.frameErr, state_reg.parErr};
                `ASC_OFS_AUX:     state_next.rdata = {5'h00, state_reg.longBreak, 2'h0};
                `ASC_OFS_DATA_HI: state_next.rdata = {state_reg.rxData[8], 7'h00};
                `ASC_OFS_DATA_LO: state_next.rdata = state_reg.rxData[7:0];
                default:          state_next.rdata = 8'h00;
            endcase
        end

        // Status read arms the flag clear by the following data access
        if (regRd && regAddr == `ASC_OFS_STATUS) begin
            state_next.clrArm = 1'b1;
        end else if (rdLo || wrLo) begin
            state_next.clrArm = 1'b0;
        end
        if (rdLo && state_reg.clrArm) begin
            state_next.rxFull   = 1'b0;
            state_next.overrun  = 1'b0;
            state_next.idleFlag = 1'b0;
            state_next.frameErr = 1'b0;
            state_next.parErr   = 1'b0;
        end
        if (wrLo && state_reg.clrArm) begin
            state_next.txDone = 1'b0;
        end

        // Register writes
        if (regWr) begin
            unique case (regAddr)
                `ASC_OFS_FRAME_LOOP: state_next.frameLoop = regWdata;
                `ASC_OFS_IRQ_ENABLE: state_next.irqEnable = regWdata;
                `ASC_OFS_AUX:     state_next.longBreak = regWdata[`ASC_AUX_LONG_BREAK];
                `ASC_OFS_DATA_HI: state_next.txData[8] = regWdata[6];
                `ASC_OFS_DATA_LO: begin
                    state_next.txData[7:0] = regWdata;
                    state_next.txEmpty     = 1'b0;
                end
                default: ;
            endcase
        end

        // Transmitter enable edge queues a preamble
        state_next.teLast = state_reg.irqEnable[`ASC_IE_TX_EN];
        if (state_reg.irqEnable[`ASC_IE_TX_EN] && !state_reg.teLast) begin
            state_next.txPre = 1'b1;
        end

        // Transmitter
        if (!state_reg.irqEnable[`ASC_IE_TX_EN]) begin
            state_next.txState = TX_IDLE;
            state_next.txLine  = 1'b1;
            state_next.txPre   = 1'b0;
            state_next.txTick  = 4'h0;
        end else begin
            unique case (state_reg.txState)
                TX_IDLE: begin
                    state_next.txLine = 1'b1;
                    state_next.txTick = 4'h0;
                    if (unitRun && state_reg.txPre) begin
                        state_next.txPre   = 1'b0;
                        state_next.txShift = 14'h3fff;
                        state_next.txBits  = frameLen;
                        state_next.txState = TX_SHIFT;
                        state_next.txDone  = 1'b0;
                    end else if (unitRun && state_reg.irqEnable[`ASC_IE_BREAK]) begin
                        state_next.txShift = 14'h0000;
                        state_next.txBits  = state_reg.longBreak
                                           ? frameLen + `ASC_BREAK_EXTRA : frameLen;
                        state_next.txState = TX_SHIFT;
                        state_next.txDone  = 1'b0;
                    end else if (unitRun && !state_reg.txEmpty) begin
                        state_next.txShift = nineBit ? {4'hf, txWord, 1'b0}
                                                     : {5'h1f, txWord[7:0], 1'b0};
                        state_next.txBits  = frameLen;
                        state_next.txState = TX_SHIFT;
                        state_next.txDone  = 1'b0;
                        if (!wrLo) begin
                            state_next.txEmpty = 1'b1;
                        end
                    end else if (state_reg.txEmpty && !state_reg.txPre) begin
                        state_next.txDone = 1'b1;
                    end
                end
                TX_SHIFT: begin
                    state_next.txLine = state_reg.txShift[0];
                    if (tick) begin
                        state_next.txTick = state_reg.txTick + 4'h1;
                        if (state_reg.txTick == `ASC_TICKS_PER_BIT) begin
                            state_next.txShift = {1'b1, state_reg.txShift[13:1]};
                            state_next.txBits  = state_reg.txBits - 4'h1;
                            if (state_reg.txBits == 4'h1) begin
                                state_next.txState = TX_IDLE;
                                state_next.txLine  = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end

        // Receiver
        if (!state_reg.irqEnable[`ASC_IE_RX_EN]) begin
            state_next.rxState = RX_IDLE;
            state_next.rxTick  = 4'h0;
            state_next.idleCnt = 4'h0;
        end else if (tick) begin
            unique case (state_reg.rxState)
                RX_IDLE: begin
                    if (!rxIn) begin
                        state_next.rxState = RX_START;
                        state_next.rxTick  = 4'h0;
                        if (!state_reg.frameLoop[`ASC_FL_IDLE_START]) begin
                            state_next.idleCnt = 4'h0;
                        end
                    end else begin
                        state_next.rxTick = state_reg.rxTick + 4'h1;
                        if (state_reg.rxTick == `ASC_TICKS_PER_BIT
                                && state_reg.idleCnt != 4'hf) begin
                            state_next.idleCnt = state_reg.idleCnt + 4'h1;
                        end
                    end
                end
                RX_START: begin
                    state_next.rxTick = state_reg.rxTick + 4'h1;
                    if (state_reg.rxTick == `ASC_START_MID) begin
                        state_next.rxTick  = 4'h0;
                        state_next.rxBits  = 4'h0;
                        state_next.rxState = rxIn ? RX_IDLE : RX_DATA;
                        state_next.idleCnt = 4'h0;
                    end
                end
                RX_DATA: begin
                    state_next.rxTick = state_reg.rxTick + 4'h1;
                    if (state_reg.rxTick == `ASC_TICKS_PER_BIT) begin
                        state_next.rxBits = state_reg.rxBits + 4'h1;
                        if (!state_reg.frameLoop[`ASC_FL_IDLE_START]) begin
                            state_next.idleCnt = rxIn ? state_reg.idleCnt + 4'h1 : 4'h0;
                        end
                        if (state_reg.rxBits != frameLen - 4'h2) begin
                            state_next.rxShift = {rxIn, state_reg.rxShift[9:1]};
                        end else begin
                            // Stop bit
                            state_next.rxState = RX_IDLE;
                            state_next.rxTick  = 4'h0;
                            if (state_reg.frameLoop[`ASC_FL_IDLE_START]) begin
                                state_next.idleCnt = 4'h0;
                            end
                            if (standby) begin
                                if (state_reg.frameLoop[`ASC_FL_RESUME]
                                        && (nineBit ? rxWord[8] : rxWord[7])) begin
                                    state_next.irqEnable[`ASC_IE_STANDBY] = 1'b0;
                                end
                            end else if (state_reg.rxFull && !(rdLo && state_reg.clrArm)) begin
                                state_next.overrun = 1'b1;
                            end else begin
                                state_next.rxData    = rxWord;
                                state_next.rxFull    = 1'b1;
                                state_next.idleArmed = 1'b1;
                                state_next.frameErr  = !rxIn;
                                state_next.parErr    = parBad;
                            end
                        end
                    end
                end
                default: state_next.rxState = RX_IDLE;
            endcase
        end

        // Idle line detection
        if (state_reg.irqEnable[`ASC_IE_RX_EN] && state_reg.rxState == RX_IDLE
                && state_reg.idleCnt >= frameLen) begin
            if (standby) begin
                if (!state_reg.frameLoop[`ASC_FL_RESUME]) begin
                    state_next.irqEnable[`ASC_IE_STANDBY] = 1'b0;
                end
                state_next.idleArmed = 1'b0;
            end else if (state_reg.idleArmed) begin
                state_next.idleFlag  = 1'b1;
                state_next.idleArmed = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg           <= '0;
            state_reg.frameLoop <= `ASC_RST_FRAME_LOOP;
            state_reg.irqEnable <= `ASC_RST_IRQ_ENABLE;
            state_reg.txEmpty   <= 1'b1;
            state_reg.txDone    <= 1'b1;
            state_reg.txLine    <= 1'b1;
            state_reg.txState   <= TX_IDLE;
            state_reg.rxState   <= RX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign regRdata     = state_reg.rdata;
    assign serialOutO   = state_reg.txLine;
    assign serialOutOeN = !state_reg.irqEnable[`ASC_IE_TX_EN];
    assign txEmptyReq   = state_reg.txEmpty && state_reg.irqEnable[`ASC_IE_TX_EMPTY];
    assign txDoneReq    = state_reg.txDone && state_reg.irqEnable[`ASC_IE_TX_DONE];
    assign rxFullReq    = (state_reg.rxFull || state_reg.overrun) && !standby
                        && state_reg.irqEnable[`ASC_IE_RX_FULL];
    assign lineQuietReq = state_reg.idleFlag && !standby
                        && state_reg.irqEnable[`ASC_IE_LINE_QUIET];
endmodule : asc_serial_ctrl
`default_nettype wire

// *** design/asc_map.svh ***
// Register offsets, field positions, reset values and timing counts for the serial control block
//
// Operation
// - Loop select set disconnects serial input pin and feeds receiver internally.
// - In loop mode receiver source picks internal transmitter line or single-wire pin.
// - Wait-mode halt set stops the serial unit while the processor waits.
// - Character length selects eight or nine data bits between start and stop.
// - Resume condition selects idle line or address mark to leave standby.
// - Idle count start selects counting ones after start bit or after stop.
// - Parity enable generates and checks parity in the top data bit.
// - Parity odd select: even sets bit on odd ones count, odd on even.
// - Transmit request when buffer-empty flag and its enable are both set.
// - Transmit-done request when done flag and its enable are both set.
// - Receive request when enabled and receive-full or overrun flag set.
// - Idle request when idle flag and its enable are both set.
// - Transmit enable turns on transmitter and gives it the output pin.
// - Raising transmit enable queues one all-ones idle preamble character.
// - Receive enable turns the receiver on and off.
// - Standby suppresses receive requests; wake condition clears standby automatically.
// - Break send pulsed sends one break of 10/11, or 13/14 zero bits.
// - Break send held sends whole breaks back to back, finishing the current one.
// - Output pin idles high and is released while transmitter is disabled.
// - Idle flag after 10 ones in eight-bit format, 11 in nine-bit.
// - While in standby an idle line never sets the idle flag.
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// Register offsets
`define ASC_OFS_FRAME_LOOP   3'h2
`define ASC_OFS_IRQ_ENABLE   3'h3
`define ASC_OFS_STATUS       3'h4
`define ASC_OFS_AUX          3'h5
`define ASC_OFS_DATA_HI      3'h6
`define ASC_OFS_DATA_LO      3'h7

// Frame and loop configuration fields
`define ASC_FL_LOOP          7
`define ASC_FL_WAIT_HALT     6
`define ASC_FL_RX_SOURCE     5
`define ASC_FL_CHAR_LEN      4
`define ASC_FL_RESUME        3
`define ASC_FL_IDLE_START    2
`define ASC_FL_PAR_EN        1
`define ASC_FL_PAR_ODD       0

// Enable and control fields
`define ASC_IE_TX_EMPTY      7
`define ASC_IE_TX_DONE       6
`define ASC_IE_RX_FULL       5
`define ASC_IE_LINE_QUIET    4
`define ASC_IE_TX_EN         3
`define ASC_IE_RX_EN         2
`define ASC_IE_STANDBY       1
`define ASC_IE_BREAK         0

// Auxiliary register field
`define ASC_AUX_LONG_BREAK   2

// Reset values
`define ASC_RST_FRAME_LOOP   8'h00
`define ASC_RST_IRQ_ENABLE   8'h00

// Timing counts
`define ASC_TICKS_PER_BIT    4'hf
`define ASC_START_MID        4'h7
`define ASC_FRAME_8          4'ha
`define ASC_FRAME_9          4'hb
`define ASC_BREAK_EXTRA      4'h3
`define ASC_BAUD_DIV_DEF     16'h000a

`endif

// *** design/asc_pkg.sv ***
// Types shared by the serial control block
`default_nettype none
package asc_pkg;
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} asc_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asc_rx_t;

    typedef struct packed {
        logic [7:0]  frameLoop;
        logic [7:0]  irqEnable;
        logic        longBreak;
        logic [8:0]  txData;
        logic        txEmpty;
        logic        txDone;
        logic        txPre;
        logic        teLast;
        logic        txLine;
        asc_tx_t     txState;
        logic [13:0] txShift;
        logic [3:0]  txBits;
        logic [3:0]  txTick;
        logic [8:0]  rxData;
        logic        rxFull;
        logic        overrun;
        logic        idleFlag;
        logic        frameErr;
        logic        parErr;
        logic        idleArmed;
        logic        clrArm;
        asc_rx_t     rxState;
        logic [3:0]  rxTick;
        logic [3:0]  rxBits;
        logic [9:0]  rxShift;
        logic [3:0]  idleCnt;
        logic [15:0] baudCnt;
        logic [7:0]  rdata;
    } asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// *** verification/asc_serial_monitor.sv ***
// Checker for the serial control block register and request ports
`default_nettype none
module asc_serial_monitor #(
    parameter logic [15:0] BAUD_DIV = 16'h000a
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    // Wait mode and output pin
    input wire logic       waitMode,
    input wire logic       serialOutO,
    input wire logic       serialOutOeN,
    // Request levels
    input wire logic       txEmptyReq,
    input wire logic       txDoneReq,
    input wire logic       rxFullReq,
    input wire logic       lineQuietReq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flShadow;
    logic [7:0] ieShadow;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Shadow copies of both control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flShadow <= 8'h00;
            ieShadow <= 8'h00;
        end else if (regWr && regAddr == 3'h2) begin
            flShadow <= regWdata;
        end else if (regWr && regAddr == 3'h3) begin
            ieShadow <= regWdata;
        end
    end

    // Read back, masking, pin control and wait freeze
    cfg_read_a: assert property (
        $past(regRd) && $past(regAddr) == 3'h2 |-> regRdata == $past(flShadow))
        else $error("config read mismatch");
    ctl_read_a: assert property (
        $past(regRd) && $past(regAddr) == 3'h3 |-> regRdata[7:2] == $past(ieShadow[7:2]))
        else $error("control read mismatch");
    tx_empty_mask_a: assert property (txEmptyReq |-> ieShadow[7])
        else $error("empty request while masked");
    tx_done_mask_a: assert property (txDoneReq |-> ieShadow[6])
        else $error("done request while masked");
    rx_full_mask_a: assert property (rxFullReq |-> ieShadow[5])
        else $error("receive request while masked");
    quiet_mask_a: assert property (lineQuietReq |-> ieShadow[4])
        else $error("idle request while masked");
    standby_mute_a: assert property (
        regWr && regAddr == 3'h3 && regWdata[1] |=> !rxFullReq && !lineQuietReq)
        else $error("request during standby");
    oe_on_a: assert property (ieShadow[3] && $past(ieShadow[3]) |-> !serialOutOeN)
        else $error("pin not driven while enabled");
    oe_off_a: assert property (!ieShadow[3] && !$past(ieShadow[3]) |-> serialOutOeN)
        else $error("pin driven while disabled");
    wait_freeze_a: assert property (
        (flShadow[6] && waitMode) [*4] |-> $stable(serialOutO))
        else $error("output moved while halted");

    // Main scenarios reached
    cover property (txEmptyReq);
    cover property (rxFullReq);
    cover property ((flShadow[6] && waitMode) [*4]);
endmodule : asc_serial_monitor

bind asc_serial_ctrl asc_serial_monitor #(.BAUD_DIV(BAUD_DIV)) u_mon (
    .mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .waitMode, .serialOutO,
    .serialOutOeN, .txEmptyReq, .txDoneReq, .rxFullReq, .lineQuietReq
);
`default_nettype wire

// *** verification/asc_remote_station.sv ***
// Remote serial station: drives the receive pin and samples the output wire
`default_nettype none
module asc_remote_station #(
    parameter int BIT = 32
) (
    // Clock
    input  wire logic mclk,
    // Serial lines
    input  wire logic serialOutO,
    input  wire logic serialOutOeN,
    output logic      serialInPin,
    output logic      serialOutI
);
    timeunit 1ns;
    timeprecision 1ps;
    logic inLevel = 1'b1;

    // Output wire is pulled up while released
    assign serialOutI  = serialOutOeN ? 1'b1 : serialOutO;
    assign serialInPin = inLevel;

    // Send start, n data bits low first, then stop
    task automatic send(input logic [8:0] v, input int n);
        inLevel <= 1'b0;
        repeat (BIT) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            inLevel <= v[i];
            repeat (BIT) @(posedge mclk);
        end
        inLevel <= 1'b1;
        repeat (BIT) @(posedge mclk);
    endtask : send

    // Wait for a falling edge, then sample n bits at mid-bit
    task automatic recv(input int n, output logic [15:0] q, output int w);
        w = 0;
        q = '0;
        while (serialOutI !== 1'b0 && w < 4000) begin
            @(posedge mclk);
            w++;
        end
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            q[i] = serialOutI;
            repeat (BIT) @(posedge mclk);
        end
    endtask : recv
endmodule : asc_remote_station
`default_nettype wire

// *** verification/test_async_serial_control_regs.sv ***
// Self-checking bench for the serial control block
`default_nettype none
module test_async_serial_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [7:0]  regWdata = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        waitMode = 1'b0;
    logic [7:0]  regRdata;
    logic        serialInPin, serialOutI, serialOutO, serialOutOeN;
    logic        txEmptyReq, txDoneReq, rxFullReq, lineQuietReq;
    logic [7:0]  d;
    logic [15:0] b;
    int          w;
    int          fails = 0;
    int          totalChecks = 0;

    asc_serial_ctrl #(.BAUD_DIV(16'h0002)) u_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .waitMode, .serialInPin, .serialOutI, .serialOutO, .serialOutOeN,
        .txEmptyReq, .txDoneReq, .rxFullReq, .lineQuietReq);
    asc_remote_station #(.BIT(32)) u_remote (.mclk, .serialOutO, .serialOutOeN, .serialInPin,
        .serialOutI);

    // Clock at 250 MHz
    always #2 mclk = ~mclk;

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        q = regRdata;
        @(posedge mclk);
    endtask : rd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Poll status until a character has arrived, bounded
    task automatic wait_rx;
        d = 8'h00;
        for (int n = 0; n < 400 && d[5] !== 1'b1; n++) rd(3'h4, d);
        chk(d[5], 1'b1);
    endtask : wait_rx

    task automatic finish_test;
        $display("Checks: %0d, mismatches: %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(3'h2, d); chk(d, 8'h00);
        rd(3'h3, d); chk(d, 8'h00);
        chk(serialOutOeN, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wr(3'h2, 8'h5a ^ {8{i[0]}});
            rd(3'h2, d); chk(d, 8'h5a ^ {8{i[0]}});
        end
        wr(3'h2, 8'h00);
        wr(3'h1, 8'hff); rd(3'h1, d); chk(d, 8'h00);
        wr(3'h3, 8'h80); chk(txEmptyReq, 1'b1);
        wr(3'h3, 8'h40); chk({txEmptyReq, txDoneReq}, 2'b01);
        // Transmit: preamble, plain, parity and nine-bit frames
        wr(3'h3, 8'h08); chk(serialOutOeN, 1'b0);
        wr(3'h7, 8'h96);
        u_remote.recv(10, b, w);
        chk(w > 280, 1'b1);
        chk(b[9:0], {1'b1, 8'h96, 1'b0});
        for (int i = 0; i < 2; i++) begin
            wr(3'h2, 8'h02 | 8'(i));
            wr(3'h7, 8'h07);
            u_remote.recv(10, b, w);
            chk(b[9:0], {1'b1, ~i[0], 7'h07, 1'b0});
        end
        wr(3'h2, 8'h10); wr(3'h6, 8'h40); wr(3'h7, 8'h5a);
        u_remote.recv(11, b, w);
        chk(b[10:0], {2'b11, 8'h5a, 1'b0});
        // Single short and long breaks in nine-bit format
        wr(3'h3, 8'h09); wr(3'h3, 8'h08);
        u_remote.recv(12, b, w);
        chk(b[11:0], 12'h800);
        wr(3'h5, 8'h04); wr(3'h3, 8'h09); wr(3'h3, 8'h08);
        u_remote.recv(15, b, w);
        chk(b[14:0], 15'h4000);
        // Wait mode halt holds a queued frame back
        wr(3'h5, 8'h00); wr(3'h2, 8'h40);
        waitMode <= 1'b1;
        wr(3'h7, 8'h55);
        u_remote.recv(1, b, w);
        chk(w, 16'd4000);
        waitMode <= 1'b0;
        u_remote.recv(10, b, w);
        chk(b[9:0], {1'b1, 8'h55, 1'b0});
        // Reception, request and standby
        wr(3'h2, 8'h08); wr(3'h3, 8'h34);
        u_remote.send(9'h0c3, 8);
        wait_rx;
        chk(rxFullReq, 1'b1);
        repeat (300) @(posedge mclk);
        chk(lineQuietReq, 1'b1);
        wr(3'h3, 8'h36); chk({rxFullReq, lineQuietReq}, 2'b00);
        rd(3'h7, d); chk(d, 8'hc3);
        wr(3'h3, 8'h20);
        u_remote.send(9'h0f0, 8);
        rd(3'h4, d); chk(d[5], 1'b0);
        // Loop and single-wire with the input pin held low
        wr(3'h2, 8'h80);
        u_remote.inLevel <= 1'b0;
        wr(3'h3, 8'h0c);
        for (int s = 0; s < 2; s++) begin
            wr(3'h2, s[0] ? 8'ha0 : 8'h80);
            wr(3'h7, 8'h3c);
            wait_rx;
            rd(3'h7, d); chk(d, 8'h3c);
        end
        finish_test;
    end
endmodule : test_async_serial_control_regs
`default_nettype wire
